// *** rtl/iee_pkg.sv ***
`default_nettype none
package iee_pkg;

  // ----------------------------------------------------------------
  // register map (word index, byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IEE_IDX_EDGE = 16'hFFF2;
  localparam logic [15:0] IEE_IDX_EN1 = 16'hFFF3;
  localparam logic [15:0] IEE_IDX_EN2 = 16'hFFF4;
  localparam logic [15:0] IEE_IDX_PINFLAG = 16'hFFF5;
  localparam int IEE_ADDR_LSB = 2;
  localparam int IEE_IDX_W = 16;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int IEE_NPIN = 5;
  localparam int IEE_NWAKE = 8;
  localparam logic [7:0] IEE_EDGE_RST = 8'h60;
  localparam logic [7:0] IEE_EDGE_FIXED = 8'h60;
  localparam logic [7:0] IEE_EDGE_WMASK = 8'h1F;
  localparam logic [7:0] IEE_EN1_RST = 8'h00;
  localparam logic [7:0] IEE_EN2_RST = 8'h01;
  localparam logic [7:0] IEE_EN2_FIXED = 8'h01;
  localparam logic [7:0] IEE_EN2_WMASK = 8'hDC;
  localparam int IEE_EN1_TA = 7;
  localparam int IEE_EN1_S1 = 6;
  localparam int IEE_EN1_WP = 5;
  localparam int IEE_EN2_DT = 7;
  localparam int IEE_EN2_AD = 6;
  localparam int IEE_EN2_TG = 4;
  localparam int IEE_EN2_TFH = 3;
  localparam int IEE_EN2_TFL = 2;

  // peripheral request flags arriving from on-chip sources
  typedef struct packed {
    logic timer_a_ovf;
    logic serial1_done;
    logic [IEE_NWAKE-1:0] wakeup;
    logic direct_transfer;
    logic adc_end;
    logic timer_g_capture;
    logic timer_g_ovf;
    logic timer_fh_cmp;
    logic timer_fh_ovf;
    logic timer_fl_cmp;
    logic timer_fl_ovf;
  } iee_src_s;

  // gated requests toward the cpu
  typedef struct packed {
    logic timer_a;
    logic serial1;
    logic [IEE_NWAKE-1:0] wakeup;
    logic [IEE_NPIN-1:0] ext_pin;
    logic direct_transfer;
    logic adc_end;
    logic timer_g;
    logic timer_f_high;
    logic timer_f_low;
  } iee_req_s;

  // whole state of the block
  typedef struct packed {
    logic [IEE_NPIN-1:0] polarity;
    logic [7:0] enable_one;
    logic [7:0] enable_two;
    logic [IEE_NPIN-1:0] sync1;
    logic [IEE_NPIN-1:0] sync2;
    logic [IEE_NPIN-1:0] prev;
    logic [IEE_NPIN-1:0] pin_flag;
    logic [IEE_NPIN-1:0] edge_event;
    iee_req_s req;
    logic cpu_irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } iee_state_s;

endpackage : iee_pkg
`default_nettype wire

// *** rtl/iee_top.sv ***
// Chosen here: the APB slave port and the register offsets.
`default_nettype none
module iee_top #(
  parameter int ADDR_W = 18
) (
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external interrupt pins, asynchronous
  input wire logic [iee_pkg::IEE_NPIN-1:0] ext_pin,
  // pin function select: 1 means the pin is an interrupt input
  input wire logic [iee_pkg::IEE_NPIN-1:0] pin_is_irq,
  // cpu global interrupt mask
  input wire logic cpu_mask,
  // on-chip request flags
  input wire iee_pkg::iee_src_s src,
  // outputs toward the cpu and pin functions
  output iee_pkg::iee_req_s req,
  output logic cpu_irq,
  output logic [iee_pkg::IEE_NPIN-1:0] edge_event,
  output logic [iee_pkg::IEE_NPIN-1:0] ext_pin_request_flag
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < iee_pkg::IEE_IDX_W + iee_pkg::IEE_ADDR_LSB) begin : g_chk
    $error("iee_top: ADDR_W too narrow for the register map");
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // word index of a byte address, zero-extended bits above dropped
  function automatic logic [15:0] word_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] s;
    s = a >> iee_pkg::IEE_ADDR_LSB;
    return s[15:0];
  endfunction

  // true when the address hits a register of this block
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    logic [15:0] i;
    logic hi_zero;
    i = word_index(a);
    hi_zero = (a >> (iee_pkg::IEE_ADDR_LSB + iee_pkg::IEE_IDX_W)) == '0;
    return hi_zero && (a[1:0] == 2'h0) &&
      (i == iee_pkg::IEE_IDX_EDGE || i == iee_pkg::IEE_IDX_EN1 ||
       i == iee_pkg::IEE_IDX_EN2 || i == iee_pkg::IEE_IDX_PINFLAG);
  endfunction

  iee_pkg::iee_state_s s_q;
  iee_pkg::iee_state_s s_d;

  logic access;
  logic wr_now;
  logic [15:0] idx;
  logic [7:0] edge_rd;
  logic [7:0] en2_rd;
  logic [iee_pkg::IEE_NPIN-1:0] rise;
  logic [iee_pkg::IEE_NPIN-1:0] fall;
  logic [iee_pkg::IEE_NPIN-1:0] sel_edge;
  logic [iee_pkg::IEE_NPIN-1:0] flag_clr;

  // ----------------------------------------------------------------
  // read views of the mixed registers
  // ----------------------------------------------------------------
  // fixed bits: 7 reads 0, 6 and 5 read 1
  assign edge_rd = iee_pkg::IEE_EDGE_FIXED |
                   {3'h0, s_q.polarity};
  // fixed bits: 5 and 1 read 0, 0 reads 1
  assign en2_rd = (s_q.enable_two & iee_pkg::IEE_EN2_WMASK) |
                  iee_pkg::IEE_EN2_FIXED;

  // ----------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------
  assign rise = s_q.sync2 & ~s_q.prev;
  assign fall = ~s_q.sync2 & s_q.prev;
  // polarity 1 picks rising, 0 picks falling, per pin
  assign sel_edge = (rise & s_q.polarity) |
                    (fall & ~s_q.polarity);

  // ----------------------------------------------------------------
  // apb access qualifiers
  // ----------------------------------------------------------------
  assign access = psel && penable && !s_q.pready;
  assign wr_now = psel && penable && s_q.pready && pwrite &&
                  !s_q.pslverr && pstrb[0];
  assign idx = word_index(paddr);
  // software clears a pin flag by writing 0 to its bit
  assign flag_clr = (wr_now && idx == iee_pkg::IEE_IDX_PINFLAG) ?
                    ~pwdata[iee_pkg::IEE_NPIN-1:0] : '0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // two-flop synchroniser, then one more stage for edge history
    s_d.sync1 = ext_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    s_d.edge_event = sel_edge;
    // flag sets on a sensed edge of an interrupt pin; set beats clear
    s_d.pin_flag = (s_q.pin_flag & ~flag_clr) |
                   (sel_edge & pin_is_irq);

    // apb: answer one cycle into the access phase
    s_d.pready = access;
    s_d.pslverr = access && !addr_hit(paddr);
    s_d.prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      unique case (idx)
        iee_pkg::IEE_IDX_EDGE: s_d.prdata = {24'h00_0000, edge_rd};
        iee_pkg::IEE_IDX_EN1: s_d.prdata = {24'h00_0000, s_q.enable_one};
        iee_pkg::IEE_IDX_EN2: s_d.prdata = {24'h00_0000, en2_rd};
        iee_pkg::IEE_IDX_PINFLAG: begin
          s_d.prdata = {27'h000_0000, s_q.pin_flag};
        end
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end

    // register writes take effect at the edge where pready is seen
    if (wr_now) begin
      if (idx == iee_pkg::IEE_IDX_EDGE) begin
        s_d.polarity = pwdata[iee_pkg::IEE_NPIN-1:0];
      end
      if (idx == iee_pkg::IEE_IDX_EN1) begin
        s_d.enable_one = pwdata[7:0];
      end
      if (idx == iee_pkg::IEE_IDX_EN2) begin
        s_d.enable_two = (pwdata[7:0] & iee_pkg::IEE_EN2_WMASK) |
                         iee_pkg::IEE_EN2_FIXED;
      end
    end

    // request gating: flag and enable, 0 blocks, 1 passes
    s_d.req.timer_a = src.timer_a_ovf &&
                      s_q.enable_one[iee_pkg::IEE_EN1_TA];
    s_d.req.serial1 = src.serial1_done &&
                      s_q.enable_one[iee_pkg::IEE_EN1_S1];
    s_d.req.wakeup = src.wakeup &
      {iee_pkg::IEE_NWAKE{s_q.enable_one[iee_pkg::IEE_EN1_WP]}};
    s_d.req.ext_pin = s_q.pin_flag &
      s_q.enable_one[iee_pkg::IEE_NPIN-1:0];
    s_d.req.direct_transfer = src.direct_transfer &&
      s_q.enable_two[iee_pkg::IEE_EN2_DT];
    s_d.req.adc_end = src.adc_end &&
      s_q.enable_two[iee_pkg::IEE_EN2_AD];
    s_d.req.timer_g = (src.timer_g_capture || src.timer_g_ovf) &&
      s_q.enable_two[iee_pkg::IEE_EN2_TG];
    s_d.req.timer_f_high = (src.timer_fh_cmp || src.timer_fh_ovf) &&
      s_q.enable_two[iee_pkg::IEE_EN2_TFH];
    s_d.req.timer_f_low = (src.timer_fl_cmp || src.timer_fl_ovf) &&
      s_q.enable_two[iee_pkg::IEE_EN2_TFL];
    // combined line offered to the cpu, held off by its mask
    s_d.cpu_irq = (|s_q.req) && !cpu_mask;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.polarity <= '0;
      s_q.enable_one <= iee_pkg::IEE_EN1_RST;
      s_q.enable_two <= iee_pkg::IEE_EN2_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign req = s_q.req;
  assign cpu_irq = s_q.cpu_irq;
  assign edge_event = s_q.edge_event;
  assign ext_pin_request_flag = s_q.pin_flag;

endmodule // iee_top
`default_nettype wire

// *** verif/iee_monitor.sv ***
`default_nettype none
module iee_monitor #(
  parameter int ADDR_W = 18
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [iee_pkg::IEE_NPIN-1:0] ext_pin,
  input wire logic [iee_pkg::IEE_NPIN-1:0] pin_is_irq,
  input wire logic cpu_mask,
  input wire iee_pkg::iee_src_s src,
  input wire iee_pkg::iee_req_s req,
  input wire logic cpu_irq,
  input wire logic [iee_pkg::IEE_NPIN-1:0] edge_event,
  input wire logic [iee_pkg::IEE_NPIN-1:0] ext_pin_request_flag
);
  // ----------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_ready_wait: assert property ($rose(psel && penable) |=> pready)
    else $error("no answer one cycle into the access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_addr: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_irq_masked: assert property (cpu_irq |-> !$past(cpu_mask))
    else $error("cpu line raised under the mask");
  a_irq_cause: assert property (cpu_irq |-> $past(|req))
    else $error("cpu line with no request");
  a_pin_gate: assert property ((req.ext_pin & ~$past(ext_pin_request_flag)) == 5'h0)
    else $error("pin request without its flag");
  a_flag_edge: assert property ((ext_pin_request_flag & ~$past(ext_pin_request_flag) & ~edge_event) == 5'h0)
    else $error("pin flag set without an edge event");
  a_flag_func: assert property ((ext_pin_request_flag & ~$past(ext_pin_request_flag) & ~$past(pin_is_irq)) == 5'h0)
    else $error("pin flag set on a non interrupt pin");
  a_event_single: assert property ((edge_event & $past(edge_event)) == 5'h0)
    else $error("edge event longer than one cycle");
  a_ta_gate: assert property (req.timer_a |-> $past(src.timer_a_ovf))
    else $error("timer a request without its flag");
  a_tg_gate: assert property (req.timer_g |-> $past(src.timer_g_capture || src.timer_g_ovf))
    else $error("timer g request without a flag");
  a_wake_gate: assert property ((req.wakeup & ~$past(src.wakeup)) == 8'h0)
    else $error("wakeup request without its flag");
endmodule // iee_monitor
bind iee_top iee_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk, .rst_b, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .ext_pin, .pin_is_irq, .cpu_mask, .src, .req, .cpu_irq, .edge_event,
  .ext_pin_request_flag);
`default_nettype wire

// *** verif/iee_src_model.sv ***
`default_nettype none
module iee_src_model (
  input wire logic clk,
  input wire logic [17:0] flags_d,
  input wire logic [4:0] pins_d,
  output iee_pkg::iee_src_s src,
  output logic [4:0] ext_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // peripheral flags and pin levels, moved just after the edge
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    src <= flags_d;
    ext_pin <= pins_d;
  end
endmodule // iee_src_model
`default_nettype wire

// *** verif/interrupt_edge_and_enable_regs_test.sv ***
`default_nettype none
module interrupt_edge_and_enable_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, psel, penable, pwrite, cpu_mask, pready, pslverr, cpu_irq;
  logic [17:0] paddr, flags_d;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0] pstrb;
  logic [4:0] pins_d, pin_is_irq, edge_event, ext_pin, fexp, pol;
  logic [4:0] ext_pin_request_flag;
  iee_pkg::iee_src_s src;
  iee_pkg::iee_req_s req, exp_req;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int errors, total_checks;
  localparam logic [17:0] A_EDGE = {iee_pkg::IEE_IDX_EDGE, 2'h0};
  localparam logic [17:0] A_EN1 = {iee_pkg::IEE_IDX_EN1, 2'h0};
  localparam logic [17:0] A_EN2 = {iee_pkg::IEE_IDX_EN2, 2'h0};
  localparam logic [17:0] A_FLAG = {iee_pkg::IEE_IDX_PINFLAG, 2'h0};
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  iee_top u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ext_pin, .pin_is_irq, .cpu_mask,
    .src, .req, .cpu_irq, .edge_event, .ext_pin_request_flag);
  iee_src_model u_src (.clk, .flags_d, .pins_d, .src, .ext_pin);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input bit ok);
    total_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH at %0t: unexpected value", $time);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] x,
                    input logic [7:0] m, input logic err);
    exp_q.push_back({err, 24'hFFFFFF, m, 24'h0, x});
    apb(1'b0, a, 32'h0);
  endtask
  // enables set, random flags and mask, gated requests compared
  task automatic gate(input logic [7:0] e1, input logic [7:0] e2);
    seed = xs(seed);
    flags_d <= seed[17:0];
    cpu_mask <= seed[31];
    wr(A_EN1, e1);
    wr(A_EN2, e2 & 8'hDC);
    repeat (3) @(posedge clk);
    exp_req = {seed[17] & e1[7], seed[16] & e1[6], seed[15:8] & {8{e1[5]}},
      fexp & e1[4:0], seed[7] & e2[7], seed[6] & e2[6],
      |seed[5:4] & e2[4], |seed[3:2] & e2[3], |seed[1:0] & e2[2]};
    check(req === exp_req);
    check(cpu_irq === ((|exp_req) & !cpu_mask));
  endtask
  task automatic print_verdict();
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // read answers compared against the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      e = exp_q.pop_front();
      check({pslverr, prdata & e[63:32]} === {e[64], e[31:0]});
    end
  end
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_b, psel, penable, pwrite, cpu_mask} = 5'h0;
    {paddr, pwdata, flags_d, pins_d, pin_is_irq, fexp} = '0;
    pstrb = 4'hF;
    seed = 32'h01D3EFCF;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(A_EDGE, 8'h60, 8'hFF, 1'b0);
    rd(A_EN1, 8'h00, 8'hFF, 1'b0);
    rd(A_EN2, 8'h01, 8'hFF, 1'b0);
    wr(A_EDGE, 8'h1F);
    rd(A_EDGE, 8'h7F, 8'hFF, 1'b0);
    wr(A_EN2, 8'hDC);
    rd(A_EN2, 8'hDD, 8'hFF, 1'b0);
    pstrb <= 4'h0;
    wr(A_EN1, 8'hFF);
    pstrb <= 4'hF;
    rd(A_EN1, 8'h00, 8'hFF, 1'b0);
    rd(A_EN1 + 18'h1, 8'h00, 8'hFF, 1'b1);
    rd(A_FLAG + 18'h4, 8'h00, 8'hFF, 1'b1);
    for (int i = 0; i < 8; i++) gate(8'h1 << i, 8'h1 << i);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      pol = seed[4:0];
      pin_is_irq <= seed[12:8];
      wr(A_EDGE, {3'h0, pol});
      pins_d <= pol;
      repeat (8) @(posedge clk);
      wr(A_FLAG, 8'h00);
      pins_d <= ~pol;
      repeat (8) @(posedge clk);
      rd(A_FLAG, 8'h00, 8'h1F, 1'b0);
      pins_d <= pol;
      repeat (8) @(posedge clk);
      fexp = pin_is_irq;
      rd(A_FLAG, fexp, 8'h1F, 1'b0);
      gate(seed[23:16], seed[31:24]);
    end
    print_verdict();
  end
endmodule // interrupt_edge_and_enable_regs_test
`default_nettype wire
